// [gpm_gpio.sv]
// General-purpose I/O module: five identical port blocks with pin function select.
//
// Function
// - A pin goes to its analog function only with digital enable clear and analog select set.
// - With alternate select and digital enable set, the pin code field picks the peripheral.
// - Every pin is configured on its own, never grouped with another pin.
// - Other pins leave reset tri-stated as plain I/O with all configuration bits zero.
// - Power-on reset and the external reset both restore every pin configuration default.
// - Port A bits 5:0 and port B bits 3:2 leave reset in peripheral code 0x1, pulls off.
// - Port C bits 3:0 leave reset in debug code 0x3 with pull-up on and pull-down off.
// - A software output pin can change state every clock cycle on repeated writes.
// - Each pin interrupt senses rising, falling, both edges, high or low, with its own mask.
// - Data reads and writes are masked per bit by the access address lines.
// - A masked-in event on port B bit 4 can issue a trigger that starts an ADC sample sequence.
// - The module is five independent identical port blocks, each its own instance.
// - A data write changes only bits whose address mask bit in bits 9:2 is one.
// - A data read returns zero for every bit whose address mask bit is zero.
// - Direction zero captures the pin into the data bit; direction one drives it out.
// - An edge interrupt holds until a one is written to its clear bit; one port output.
`timescale 1ns/10ps
`default_nettype none

module gpm_port #(
   parameter int W = 8,
   parameter logic [W-1:0] AFSEL_RST = '0,
   parameter logic [W-1:0] DIGITAL_ENABLE_RST = '0,
   parameter logic [W-1:0] PUR_RST = '0,
   parameter logic [W-1:0] PDR_RST = '0,
   parameter logic [4*W-1:0] PCTL_RST = '0,
   parameter logic [W-1:0] ADC_MASK = '0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Register write command.
   input wire logic wr_en,
   input wire gpm_pkg::gpm_reg_t wr_reg,
   input wire logic [gpm_pkg::GPM_MASK_W-1:0] wr_mask,
   input wire logic [gpm_pkg::GPM_DATA_W-1:0] wr_data,
   // Register read command and answer.
   input wire logic rd_en,
   input wire gpm_pkg::gpm_reg_t rd_reg,
   input wire logic [gpm_pkg::GPM_MASK_W-1:0] rd_mask,
   output logic [gpm_pkg::GPM_DATA_W-1:0] rd_data,
   output logic rd_valid,
   // Pads.
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe,
   output logic [W-1:0] pull_up,
   output logic [W-1:0] pull_down,
   output logic [W-1:0] analog_en,
   // Peripheral signals.
   input wire logic [gpm_pkg::GPM_NCODE-1:0][W-1:0] alt_out,
   input wire logic [gpm_pkg::GPM_NCODE-1:0][W-1:0] alt_oe,
   output logic [W-1:0] periph_in,
   // Events.
   output logic irq,
   output logic adc_trig
);
   import gpm_pkg::*;

   typedef struct packed {
      logic [W-1:0] data;
      logic [W-1:0] dir;
      logic [W-1:0] is;
      logic [W-1:0] ibe;
      logic [W-1:0] iev;
      logic [W-1:0] im;
      logic [W-1:0] afsel;
      logic [W-1:0] digital_enable;
      logic [W-1:0] analog_select;
      logic [W-1:0] pdr;
      logic [W-1:0] pur;
      logic [GPM_CODE_W*W-1:0] pctl;
      logic [W-1:0] pin_out;
      logic [W-1:0] pin_oe;
      logic [W-1:0] pull_up;
      logic [W-1:0] pull_down;
      logic [W-1:0] analog_en;
      logic [W-1:0] periph_in;
      logic [GPM_DATA_W-1:0] rd_data;
      logic rd_valid;
      logic irq;
      logic adc_trig;
   } gpm_port_state_t;

   localparam gpm_port_state_t RST_STATE = '{
      data: '0,
      dir: '0,
      is: '0,
      ibe: '0,
      iev: '0,
      im: '0,
      afsel: AFSEL_RST,
      digital_enable: DIGITAL_ENABLE_RST,
      analog_select: '0,
      pdr: PDR_RST,
      pur: PUR_RST,
      pctl: PCTL_RST,
      pin_out: '0,
      pin_oe: '0,
      pull_up: PUR_RST,
      pull_down: PDR_RST,
      analog_en: '0,
      periph_in: '0,
      rd_data: '0,
      rd_valid: 1'b0,
      irq: 1'b0,
      adc_trig: 1'b0
   };

   gpm_port_state_t s_reg;
   gpm_port_state_t s_next;
   logic [W-1:0] dig_in;
   logic [W-1:0] clear_bits;
   logic [W-1:0] raw_status;
   logic [W-1:0] pin_event;
   logic [W-1:0] wmask;
   logic [W-1:0] rmask;

   // Peripheral code of one pin.
   function automatic logic [GPM_CODE_W-1:0] pin_code(
      input logic [GPM_CODE_W*W-1:0] pctl,
      input int idx
   );
      pin_code = pctl[idx*GPM_CODE_W +: GPM_CODE_W];
   endfunction : pin_code

   ////////////////////////////////////////////////////////////////////////////

   // Interrupt detection for all pins of this port.
   gpm_pin_irq #(
      .W(W)
   ) u_irq (
      .clk(clk),
      .nrst(nrst),
      .pin_level(dig_in),
      .sense_level(s_reg.is),
      .both_edges(s_reg.ibe),
      .event_high(s_reg.iev),
      .clear_bits(clear_bits),
      .raw_status(raw_status),
      .pin_event(pin_event)
   );

   ////////////////////////////////////////////////////////////////////////////

   // Command decode, pin routing and status.
   always_comb begin
      s_next = s_reg;
      s_next.rd_valid = 1'b0;
      dig_in = pin_in & s_reg.digital_enable;
      wmask = wr_mask[W-1:0];
      rmask = rd_mask[W-1:0];
      clear_bits = '0;
      if (wr_en) begin
         unique case (wr_reg)
            GPM_R_DATA: s_next.data = (s_reg.data & ~wmask) | (wr_data[W-1:0] & wmask);
            GPM_R_DIR: s_next.dir = wr_data[W-1:0];
            GPM_R_IS: s_next.is = wr_data[W-1:0];
            GPM_R_IBE: s_next.ibe = wr_data[W-1:0];
            GPM_R_IEV: s_next.iev = wr_data[W-1:0];
            GPM_R_IM: s_next.im = wr_data[W-1:0];
            GPM_R_ICR: clear_bits = wr_data[W-1:0];
            GPM_R_AFSEL: s_next.afsel = wr_data[W-1:0];
            GPM_R_DIGITAL_ENABLE: s_next.digital_enable = wr_data[W-1:0];
            GPM_R_ANALOG_SELECT: s_next.analog_select = wr_data[W-1:0];
            GPM_R_PDR: s_next.pdr = wr_data[W-1:0];
            GPM_R_PUR: s_next.pur = wr_data[W-1:0];
            GPM_R_PCTL: s_next.pctl = wr_data[GPM_CODE_W*W-1:0];
            default: s_next.pctl = s_reg.pctl;
         endcase
      end
      // Input pins keep their data bit following the pad.
      s_next.data = (s_next.data & s_reg.dir) | (dig_in & ~s_reg.dir);
      for (int i = 0; i < W; i++) begin
         if (s_reg.afsel[i] && s_reg.digital_enable[i]) begin
            s_next.pin_out[i] = alt_out[pin_code(s_reg.pctl, i)][i];
            s_next.pin_oe[i] = alt_oe[pin_code(s_reg.pctl, i)][i];
         end else if (s_reg.afsel[i]) begin
            s_next.pin_out[i] = 1'b0;
            s_next.pin_oe[i] = 1'b0;
         end else begin
            s_next.pin_out[i] = s_reg.data[i];
            s_next.pin_oe[i] = s_reg.dir[i];
         end
      end
      s_next.pull_up = s_reg.pur;
      s_next.pull_down = s_reg.pdr;
      s_next.analog_en = ~s_reg.digital_enable & s_reg.analog_select;
      s_next.periph_in = dig_in & s_reg.afsel;
      s_next.irq = |(raw_status & s_reg.im);
      s_next.adc_trig = |(pin_event & s_reg.im & ADC_MASK);
      if (rd_en) begin
         s_next.rd_valid = 1'b1;
         unique case (rd_reg)
            GPM_R_DATA: s_next.rd_data = GPM_DATA_W'(s_reg.data & rmask);
            GPM_R_DIR: s_next.rd_data = GPM_DATA_W'(s_reg.dir);
            GPM_R_IS: s_next.rd_data = GPM_DATA_W'(s_reg.is);
            GPM_R_IBE: s_next.rd_data = GPM_DATA_W'(s_reg.ibe);
            GPM_R_IEV: s_next.rd_data = GPM_DATA_W'(s_reg.iev);
            GPM_R_IM: s_next.rd_data = GPM_DATA_W'(s_reg.im);
            GPM_R_AFSEL: s_next.rd_data = GPM_DATA_W'(s_reg.afsel);
            GPM_R_DIGITAL_ENABLE: s_next.rd_data = GPM_DATA_W'(s_reg.digital_enable);
            GPM_R_ANALOG_SELECT: s_next.rd_data = GPM_DATA_W'(s_reg.analog_select);
            GPM_R_PDR: s_next.rd_data = GPM_DATA_W'(s_reg.pdr);
            GPM_R_PUR: s_next.rd_data = GPM_DATA_W'(s_reg.pur);
            GPM_R_PCTL: s_next.rd_data = GPM_DATA_W'(s_reg.pctl);
            GPM_R_RIS: s_next.rd_data = GPM_DATA_W'(raw_status);
            GPM_R_MIS: s_next.rd_data = GPM_DATA_W'(raw_status & s_reg.im);
            default: s_next.rd_data = '0;
         endcase
      end
   end

   // Both reset sources arrive merged on nrst and load the defaults.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= RST_STATE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rd_data = s_reg.rd_data;
   assign rd_valid = s_reg.rd_valid;
   assign pin_out = s_reg.pin_out;
   assign pin_oe = s_reg.pin_oe;
   assign pull_up = s_reg.pull_up;
   assign pull_down = s_reg.pull_down;
   assign analog_en = s_reg.analog_en;
   assign periph_in = s_reg.periph_in;
   assign irq = s_reg.irq;
   assign adc_trig = s_reg.adc_trig;

endmodule : gpm_port

////////////////////////////////////////////////////////////////////////////////

module gpm_gpio #(
   parameter int NPORT = gpm_pkg::GPM_NPORT,
   parameter int W = gpm_pkg::GPM_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Register write command.
   input wire logic wr_en,
   input wire logic [gpm_pkg::GPM_PORT_SEL_W-1:0] wr_port,
   input wire gpm_pkg::gpm_reg_t wr_reg,
   input wire logic [gpm_pkg::GPM_MASK_W-1:0] wr_mask,
   input wire logic [gpm_pkg::GPM_DATA_W-1:0] wr_data,
   // Register read command and answers.
   input wire logic rd_en,
   input wire logic [gpm_pkg::GPM_PORT_SEL_W-1:0] rd_port,
   input wire gpm_pkg::gpm_reg_t rd_reg,
   input wire logic [gpm_pkg::GPM_MASK_W-1:0] rd_mask,
   output logic [NPORT-1:0][gpm_pkg::GPM_DATA_W-1:0] rd_data,
   output logic [NPORT-1:0] rd_valid,
   // Pads.
   input wire logic [NPORT-1:0][W-1:0] pin_in,
   output logic [NPORT-1:0][W-1:0] pin_out,
   output logic [NPORT-1:0][W-1:0] pin_oe,
   output logic [NPORT-1:0][W-1:0] pull_up,
   output logic [NPORT-1:0][W-1:0] pull_down,
   output logic [NPORT-1:0][W-1:0] analog_en,
   // Peripheral signals.
   input wire logic [NPORT-1:0][gpm_pkg::GPM_NCODE-1:0][W-1:0] alt_out,
   input wire logic [NPORT-1:0][gpm_pkg::GPM_NCODE-1:0][W-1:0] alt_oe,
   output logic [NPORT-1:0][W-1:0] periph_in,
   // Events.
   output logic [NPORT-1:0] irq,
   output logic [NPORT-1:0] adc_trig
);
   import gpm_pkg::*;

   // One separate port block per port.
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      gpm_port #(
         .W(W),
         .AFSEL_RST(W'(GPM_AFSEL_RST[p])),
         .DIGITAL_ENABLE_RST(W'(GPM_DIGITAL_ENABLE_RST[p])),
         .PUR_RST(W'(GPM_PUR_RST[p])),
         .PDR_RST(W'(GPM_PDR_RST[p])),
         .PCTL_RST((GPM_CODE_W*W)'(GPM_PCTL_RST[p])),
         .ADC_MASK(W'(GPM_ADC_MASK[p]))
      ) u_port (
         .clk(clk),
         .nrst(nrst),
         .wr_en(wr_en && (wr_port == GPM_PORT_SEL_W'(p))),
         .wr_reg(wr_reg),
         .wr_mask(wr_mask),
         .wr_data(wr_data),
         .rd_en(rd_en && (rd_port == GPM_PORT_SEL_W'(p))),
         .rd_reg(rd_reg),
         .rd_mask(rd_mask),
         .rd_data(rd_data[p]),
         .rd_valid(rd_valid[p]),
         .pin_in(pin_in[p]),
         .pin_out(pin_out[p]),
         .pin_oe(pin_oe[p]),
         .pull_up(pull_up[p]),
         .pull_down(pull_down[p]),
         .analog_en(analog_en[p]),
         .alt_out(alt_out[p]),
         .alt_oe(alt_oe[p]),
         .periph_in(periph_in[p]),
         .irq(irq[p]),
         .adc_trig(adc_trig[p])
      );
   end

endmodule : gpm_gpio

`default_nettype wire

// [gpm_gpio_asserts.sv]
// Concurrent checks on the ports of the pin function select module.
`timescale 1ns/10ps
`default_nettype none

module gpm_gpio_asserts #(
   parameter int NPORT = gpm_pkg::GPM_NPORT,
   parameter int W = gpm_pkg::GPM_W
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Commands.
   input wire logic wr_en,
   input wire logic [gpm_pkg::GPM_PORT_SEL_W-1:0] wr_port,
   input wire logic rd_en,
   input wire logic [gpm_pkg::GPM_PORT_SEL_W-1:0] rd_port,
   input wire gpm_pkg::gpm_reg_t rd_reg,
   input wire logic [gpm_pkg::GPM_MASK_W-1:0] rd_mask,
   // Answers and pads.
   input wire logic [NPORT-1:0][gpm_pkg::GPM_DATA_W-1:0] rd_data,
   input wire logic [NPORT-1:0] rd_valid,
   input wire logic [NPORT-1:0][W-1:0] pull_up,
   input wire logic [NPORT-1:0][W-1:0] pull_down,
   input wire logic [NPORT-1:0][W-1:0] analog_en,
   input wire logic [NPORT-1:0][W-1:0] periph_in,
   input wire logic [NPORT-1:0] irq,
   input wire logic [NPORT-1:0] adc_trig
);
   import gpm_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   property p_rd_one;
      rd_en && rd_port < 3'h5 |=> $onehot(rd_valid) && rd_valid[$past(rd_port)];
   endproperty
   a_rd_one: assert property (p_rd_one) else $error("read answer missing");
   property p_rd_none;
      !(rd_en && rd_port < 3'h5) |=> rd_valid == '0;
   endproperty
   a_rd_none: assert property (p_rd_none) else $error("answer without read");
   property p_rd_mask;
      rd_en && rd_port < 3'h5 && rd_reg == GPM_R_DATA
         |=> (rd_data[$past(rd_port)] & ~{24'h000000, $past(rd_mask)}) == 32'h0;
   endproperty
   a_rd_mask: assert property (p_rd_mask) else $error("masked bit read as one");
   property p_analog;
      (analog_en & periph_in) == '0;
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin feeds digital");
   property p_adc_port;
      (adc_trig & 5'h1d) == 5'h00;
   endproperty
   a_adc_port: assert property (p_adc_port) else $error("trigger on wrong port");
   property p_adc_irq;
      adc_trig[1] && !$past(wr_en) |=> irq[1];
   endproperty
   a_adc_irq: assert property (p_adc_irq) else $error("trigger without interrupt");
   property p_pull_iso;
      wr_en && wr_port == 3'h3 && !$past(wr_en)
         |=> $stable(pull_up[2:0]) && $stable(pull_down[2:0]) && $stable(analog_en[2:0]);
   endproperty
   a_pull_iso: assert property (p_pull_iso) else $error("other port changed");
   property p_cfg_hold;
      !wr_en && !$past(wr_en) |=> $stable(pull_up) && $stable(pull_down) && $stable(analog_en);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("config moved alone");
endmodule : gpm_gpio_asserts

bind gpm_gpio gpm_gpio_asserts #(.NPORT(NPORT), .W(W)) i_gpm_gpio_asserts (
   .clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_port(wr_port), .rd_en(rd_en),
   .rd_port(rd_port), .rd_reg(rd_reg), .rd_mask(rd_mask), .rd_data(rd_data),
   .rd_valid(rd_valid), .pull_up(pull_up), .pull_down(pull_down), .analog_en(analog_en),
   .periph_in(periph_in), .irq(irq), .adc_trig(adc_trig));
`default_nettype wire

// [gpm_gpio_test.sv]
// Self-checking bench of the pin function select module.
`timescale 1ns/10ps
`default_nettype none

module gpm_gpio_test;
   import gpm_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr_en = 1'b0;
   logic [2:0] wr_port = 3'h0;
   gpm_reg_t wr_reg = GPM_R_DATA;
   logic [7:0] wr_mask = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic rd_en = 1'b0;
   logic [2:0] rd_port = 3'h0;
   gpm_reg_t rd_reg = GPM_R_DATA;
   logic [7:0] rd_mask = 8'h00;
   logic [4:0][31:0] rd_data;
   logic [4:0] rd_valid, irq, adc_trig;
   logic [4:0][7:0] pin_in, pin_out, pin_oe, pull_up, pull_down, analog_en, periph_in;
   logic [4:0][7:0] ext_en = {8'h00, 8'hf0, 8'h00, 8'h10, 8'h00};
   logic [4:0][7:0] ext_val = '0;
   logic [4:0][15:0][7:0] alt_out, alt_oe;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   logic trig_seen = 1'b0;

   always #10 clk = ~clk;

   gpm_gpio i_gpm_gpio (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_port(wr_port),
      .wr_reg(wr_reg), .wr_mask(wr_mask), .wr_data(wr_data), .rd_en(rd_en),
      .rd_port(rd_port), .rd_reg(rd_reg), .rd_mask(rd_mask), .rd_data(rd_data),
      .rd_valid(rd_valid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_up(pull_up), .pull_down(pull_down), .analog_en(analog_en), .alt_out(alt_out),
      .alt_oe(alt_oe), .periph_in(periph_in), .irq(irq), .adc_trig(adc_trig));
   gpm_pads i_gpm_pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pull_up),
      .pull_down(pull_down), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in),
      .alt_out(alt_out), .alt_oe(alt_oe));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc++;
      if (adc_trig[1] === 1'b1) begin
         trig_seen = 1'b1;
      end
      if (cyc == 5000) begin
         err_count++;
         results();
      end
   end

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] p, input gpm_reg_t r, input logic [7:0] m,
      input logic [31:0] d);
      @(negedge clk);
      wr_port = p;
      wr_reg = r;
      wr_mask = m;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] p, input gpm_reg_t r, input logic [7:0] m,
      output logic [31:0] d);
      @(negedge clk);
      rd_port = p;
      rd_reg = r;
      rd_mask = m;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      chk(rd_valid[p], 1'b1);
      d = rd_data[p];
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      logic [4:0][7:0] fsel = {8'h00, 8'h00, 8'h0f, 8'h0c, 8'h3f};
      logic [4:0][31:0] code = {32'h0, 32'h0, 32'h3333, 32'h1100, 32'h0011_1111};
      @(negedge clk);
      nrst = 1'b0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      chk(pull_up, {8'h00, 8'h00, 8'h0f, 8'h00, 8'h00});
      chk(pull_down | analog_en, 40'h0);
      chk(pin_oe[0][5:0], alt_oe[0][1][5:0]);
      chk(pin_oe[1][3:2], alt_oe[1][1][3:2]);
      chk(pin_oe[2][3:0], alt_oe[2][3][3:0]);
      chk(pin_oe[3] | pin_oe[4], 8'h00);
      chk(periph_in[2], 8'h0f);
      for (int p = 0; p < 5; p++) begin
         rd(3'(p), GPM_R_AFSEL, 8'h00, d);
         chk(d, {24'h0, fsel[p]});
         rd(3'(p), GPM_R_DIGITAL_ENABLE, 8'h00, d);
         chk(d, {24'h0, fsel[p]});
         rd(3'(p), GPM_R_PCTL, 8'h00, d);
         chk(d, code[p]);
      end
   endtask : t_reset

   task automatic t_data();
      logic [31:0] d;
      wr(3'h3, GPM_R_DIR, 8'h00, 32'hff);
      wr(3'h3, GPM_R_DATA, 8'hff, 32'h00);
      wr(3'h3, GPM_R_DATA, 8'h26, 32'heb);
      @(negedge clk);
      chk(pin_out[3], 8'h22);
      chk(pin_oe[3], 8'hff);
      rd(3'h3, GPM_R_DATA, 8'h31, d);
      chk(d, 32'h20);
      for (int k = 1; k < 5; k++) begin
         wr(3'h3, GPM_R_DATA, 8'h01, 32'(k[0]));
         chk(pin_out[3][0], !k[0]);
      end
      wr(3'h3, GPM_R_DIR, 8'h00, 32'h0f);
      wr(3'h3, GPM_R_DIGITAL_ENABLE, 8'h00, 32'hff);
      ext_val[3] = 8'ha0;
      repeat (3) @(negedge clk);
      rd(3'h3, GPM_R_DATA, 8'hff, d);
      chk(d, 32'ha2);
   endtask : t_data

   task automatic t_func();
      wr(3'h4, GPM_R_PCTL, 8'h00, 32'h5);
      wr(3'h4, GPM_R_DIGITAL_ENABLE, 8'h00, 32'h01);
      wr(3'h4, GPM_R_AFSEL, 8'h00, 32'h01);
      @(negedge clk);
      chk({pin_oe[4][0], pin_out[4][0]}, {alt_oe[4][5][0], alt_out[4][5][0]});
      wr(3'h4, GPM_R_ANALOG_SELECT, 8'h00, 32'h02);
      @(negedge clk);
      chk(analog_en[4], 8'h02);
      chk({pin_oe[4][0], pin_out[4][0]}, {alt_oe[4][5][0], alt_out[4][5][0]});
      wr(3'h4, GPM_R_PUR, 8'h00, 32'h80);
      wr(3'h4, GPM_R_PDR, 8'h00, 32'h40);
      wr(3'h4, GPM_R_DIGITAL_ENABLE, 8'h00, 32'h03);
      wr(3'h4, GPM_R_AFSEL, 8'h00, 32'h00);
      wr(3'h4, GPM_R_DIR, 8'h00, 32'h01);
      @(negedge clk);
      chk(analog_en[4], 8'h00);
      chk({pin_oe[4][0], pin_out[4][0]}, 2'b10);
      chk({pull_up[4], pull_down[4]}, 16'h8040);
   endtask : t_func

   task automatic t_irq();
      logic [31:0] d;
      logic [4:0][2:0] mode = {3'b100, 3'b101, 3'b010, 3'b000, 3'b001};
      logic [4:0] up = 5'b01101;
      logic [4:0] dn = 5'b10110;
      wr(3'h1, GPM_R_DIGITAL_ENABLE, 8'h00, 32'h1c);
      for (int m = 0; m < 5; m++) begin
         wr(3'h1, GPM_R_IM, 8'h00, 32'h00);
         ext_val[1][4] = 1'b0;
         wr(3'h1, GPM_R_IS, 8'h00, {27'h0, mode[m][2], 4'h0});
         wr(3'h1, GPM_R_IBE, 8'h00, {27'h0, mode[m][1], 4'h0});
         wr(3'h1, GPM_R_IEV, 8'h00, {27'h0, mode[m][0], 4'h0});
         wr(3'h1, GPM_R_ICR, 8'h00, 32'h10);
         wr(3'h1, GPM_R_IM, 8'h00, 32'h10);
         trig_seen = 1'b0;
         ext_val[1][4] = 1'b1;
         repeat (4) @(negedge clk);
         chk(irq[1], up[m]);
         if (m == 0) begin
            chk(trig_seen, 1'b1);
         end
         wr(3'h1, GPM_R_ICR, 8'h00, 32'h10);
         ext_val[1][4] = 1'b0;
         repeat (4) @(negedge clk);
         chk(irq[1], dn[m]);
      end
      wr(3'h1, GPM_R_IM, 8'h00, 32'h00);
      @(negedge clk);
      chk(irq[1], 1'b0);
      rd(3'h1, GPM_R_RIS, 8'h00, d);
      chk(d[4], 1'b1);
      rd(3'h1, GPM_R_MIS, 8'h00, d);
      chk(d, 32'h0);
   endtask : t_irq

   initial begin
      t_reset();
      t_data();
      t_func();
      t_irq();
      t_reset();
      results();
   end
endmodule : gpm_gpio_test
`default_nettype wire

// [gpm_pads.sv]
// Pad and peripheral source model on the far side of the port pins.
`timescale 1ns/10ps
`default_nettype none

module gpm_pads (
   // Clock.
   input wire logic clk,
   // Device pad controls.
   input wire logic [4:0][7:0] pin_out,
   input wire logic [4:0][7:0] pin_oe,
   input wire logic [4:0][7:0] pull_up,
   input wire logic [4:0][7:0] pull_down,
   // External drivers.
   input wire logic [4:0][7:0] ext_en,
   input wire logic [4:0][7:0] ext_val,
   // Pad levels and peripheral sources.
   output logic [4:0][7:0] pin_in,
   output logic [4:0][15:0][7:0] alt_out,
   output logic [4:0][15:0][7:0] alt_oe
);
   logic [4:0][7:0] last_reg = '0;

   // A pad nobody drives and nothing pulls shows the inverse of its last level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pull_up | (~pull_down & ~last_reg)));

   // Only a driven or pulled pad updates the remembered level.
   always @(posedge clk) begin
      last_reg <= ((pin_oe | ext_en | pull_up | pull_down) & pin_in)
         | (~(pin_oe | ext_en | pull_up | pull_down) & last_reg);
   end

   // Each peripheral code drives its own pattern.
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         for (int c = 0; c < 16; c++) begin
            alt_out[p][c] = 8'(c * 37 + p);
            alt_oe[p][c] = 8'(c * 59);
         end
      end
   end
endmodule : gpm_pads
`default_nettype wire

// [gpm_pin_irq.sv]
// Per-pin interrupt detection for one port, all pins side by side.
`timescale 1ns/10ps
`default_nettype none

module gpm_pin_irq #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Pin levels and sense controls.
   input wire logic [W-1:0] pin_level,
   input wire logic [W-1:0] sense_level,
   input wire logic [W-1:0] both_edges,
   input wire logic [W-1:0] event_high,
   input wire logic [W-1:0] clear_bits,
   // Raw status with edges held until cleared; pin event one cycle per edge or every cycle a level matches.
   output logic [W-1:0] raw_status,
   output logic [W-1:0] pin_event
);
   import gpm_pkg::*;

   typedef struct packed {
      logic [W-1:0] prev;
      logic [W-1:0] raw;
   } gpm_irq_state_t;

   gpm_irq_state_t s_reg;
   gpm_irq_state_t s_next;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   logic [W-1:0] edge_hit;
   logic [W-1:0] level_hit;

   ////////////////////////////////////////////////////////////////////////////

   // Edge pins latch until cleared, a new edge beats a clear, level pins follow the pin.
   always_comb begin
      rise = pin_level & ~s_reg.prev;
      fall = ~pin_level & s_reg.prev;
      edge_hit = ~sense_level & ((both_edges & (rise | fall)) |
                 (~both_edges & ((event_high & rise) | (~event_high & fall))));
      level_hit = sense_level & ~(pin_level ^ event_high);
      s_next.prev = pin_level;
      s_next.raw = level_hit | (~sense_level & (edge_hit | (s_reg.raw & ~clear_bits)));
      pin_event = edge_hit | level_hit;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign raw_status = s_reg.raw;

endmodule : gpm_pin_irq

`default_nettype wire

// [gpm_pkg.sv]
// Package with widths, register selectors and reset values of the port pins.
package gpm_pkg;

   localparam int GPM_NPORT = 5;
   localparam int GPM_W = 8;
   localparam int GPM_CODE_W = 4;
   localparam int GPM_NCODE = 16;
   localparam int GPM_MASK_W = 8;
   localparam int GPM_DATA_W = 32;
   localparam int GPM_PORT_SEL_W = 3;

   // Register selectors of the command port.
   typedef enum logic [3:0] {
      GPM_R_DATA,
      GPM_R_DIR,
      GPM_R_IS,
      GPM_R_IBE,
      GPM_R_IEV,
      GPM_R_IM,
      GPM_R_ICR,
      GPM_R_AFSEL,
      GPM_R_DIGITAL_ENABLE,
      GPM_R_ANALOG_SELECT,
      GPM_R_PDR,
      GPM_R_PUR,
      GPM_R_PCTL,
      GPM_R_RIS,
      GPM_R_MIS
   } gpm_reg_t;

   // Reset values per port, index 0 is port A and index 4 is port E.
   localparam logic [GPM_NPORT-1:0][GPM_W-1:0] GPM_AFSEL_RST =
      {8'h00, 8'h00, 8'h0f, 8'h0c, 8'h3f};
   localparam logic [GPM_NPORT-1:0][GPM_W-1:0] GPM_DIGITAL_ENABLE_RST =
      {8'h00, 8'h00, 8'h0f, 8'h0c, 8'h3f};
   localparam logic [GPM_NPORT-1:0][GPM_W-1:0] GPM_PUR_RST =
      {8'h00, 8'h00, 8'h0f, 8'h00, 8'h00};
   localparam logic [GPM_NPORT-1:0][GPM_W-1:0] GPM_PDR_RST =
      {8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [GPM_NPORT-1:0][GPM_CODE_W*GPM_W-1:0] GPM_PCTL_RST =
      {32'h0000_0000, 32'h0000_0000, 32'h0000_3333, 32'h0000_1100, 32'h0011_1111};
   localparam logic [GPM_NPORT-1:0][GPM_W-1:0] GPM_ADC_MASK =
      {8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
   localparam logic [GPM_W-1:0] GPM_ZERO_RST = 8'h00;

endpackage : gpm_pkg
